/* File: rtl/pdba_pkg.sv */
// constants for the processor dma bus arbiter
// assumes a 25 MHz board clock and a clock-high start pulse
// from the processor clock generator
package pdba_pkg;

  // ==========================================================
  // clock
  // ==========================================================
  localparam int CLK_PERIOD_NS = 40;
  // nominal processor clock-high spacing, for reference only
  localparam int CPU_CYCLE_NS  = 290;

  // ==========================================================
  // grant delay: least time, rounded up
  // ==========================================================
  localparam int GNT_DLY_NS  = 65;
  localparam int GNT_DLY_RAW =
    (GNT_DLY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int GNT_DLY_CYC = (GNT_DLY_RAW < 1) ? 1 : GNT_DLY_RAW;
  localparam int GNT_W       = $clog2(GNT_DLY_CYC + 1);
  localparam logic [GNT_W-1:0] GNT_LOAD = GNT_W'(GNT_DLY_CYC);
  localparam logic [GNT_W-1:0] GNT_FIRE = GNT_W'(1);
  localparam logic [GNT_W-1:0] GNT_IDLE = GNT_W'(0);

  // ==========================================================
  // select acknowledge timeout: longest time, rounded down
  // ==========================================================
  localparam int TMO_NS      = 18000;
  localparam int TMO_RAW     = TMO_NS / CLK_PERIOD_NS;
  localparam int TMO_CYC     = (TMO_RAW < 1) ? 1 : TMO_RAW;
  localparam int TMO_W       = $clog2(TMO_CYC + 1);
  localparam logic [TMO_W-1:0] TMO_LAST = TMO_W'(TMO_CYC - 1);
  localparam logic [TMO_W-1:0] TMO_ZERO = TMO_W'(0);
  localparam logic [TMO_W-1:0] TMO_STEP = TMO_W'(1);

  // ==========================================================
  // reset values
  // ==========================================================
  localparam logic FLAG_RST   = 1'h0;
  localparam logic STROBE_RST = 1'h1;

endpackage : pdba_pkg

/* File: rtl/pdba_sync.sv */
// two-stage level synchroniser on the board clock
// assumes the input may change at any time
`timescale 1ns/1ps
`default_nettype none

module pdba_sync (
  input  wire logic sys_clk_in,
  input  wire logic rst_b_in,
  input  wire logic async_in,
  output logic      sync_out
);
  import pdba_pkg::*;

  logic meta_q;
  logic sync_q;

  // ==========================================================
  // stages
  // ==========================================================
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      meta_q <= FLAG_RST;
      sync_q <= FLAG_RST;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;

endmodule : pdba_sync

`default_nettype wire

/* File: rtl/pdba_arbiter.sv */
// dma bus arbiter of the processor board
// assumes clk_high_start_in pulses one board clock at the start
// of each processor clock-high time; bus inputs are active low
`timescale 1ns/1ps
`default_nettype none

module pdba_arbiter (
  input  wire logic sys_clk_in,
  input  wire logic rst_b_in,
  input  wire logic clk_high_start_in,
  input  wire logic cpu_bus_cycle_active_n_in,
  input  wire logic bus_dma_request_n_in,
  input  wire logic bus_select_ack_n_in,
  input  wire logic bus_sync_n_in,
  output logic      bus_dma_grant_out_n_out,
  output logic      bus_drivers_disable_out,
  output logic      clk_restart_block_out,
  output logic      ack_timeout_out
);
  import pdba_pkg::*;

  // ==========================================================
  // state
  // ==========================================================
  logic             dma_enable_latch_q;
  logic             dma_enable_latch_d;
  logic             grant_q;
  logic             grant_d;
  logic             bus_dis_q;
  logic             bus_dis_d;
  logic             armed_q;
  logic             armed_d;
  logic             strobe_prev_q;
  logic             tmo_q;
  logic [GNT_W-1:0] dly_q;
  logic [GNT_W-1:0] dly_d;
  logic [TMO_W-1:0] tmr_q;
  logic [TMO_W-1:0] tmr_d;

  // ==========================================================
  // request path
  // ==========================================================
  logic synced_dma_request;
  logic gated_dma_request;
  logic rearbitrate_strobe_n_trig;
  logic rearbitrate_strobe_n_trig_s;
  logic rearbitrate_strobe_n;

  pdba_sync u_req_sync (
    .sys_clk_in (sys_clk_in),
    .rst_b_in   (rst_b_in),
    .async_in   (~bus_dma_request_n_in),
    .sync_out   (synced_dma_request)
  );

  // high bus cycle flag means no cpu cycle is in progress
  assign gated_dma_request =
    synced_dma_request & cpu_bus_cycle_active_n_in;

  // ==========================================================
  // rearbitration trigger
  // ==========================================================
  assign rearbitrate_strobe_n_trig =
    armed_q & bus_select_ack_n_in & bus_sync_n_in;

  pdba_sync u_rearbitrate_strobe_n_sync (
    .sys_clk_in (sys_clk_in),
    .rst_b_in   (rst_b_in),
    .async_in   (rearbitrate_strobe_n_trig),
    .sync_out   (rearbitrate_strobe_n_trig_s)
  );

  assign rearbitrate_strobe_n = ~rearbitrate_strobe_n_trig_s;

  // ==========================================================
  // decode
  // ==========================================================
  logic en_set;
  logic ack_seen;
  logic timeout;
  logic rearbitrate_strobe_n_evt;
  logic rearbitrate_strobe_n_clear;
  logic rearbitrate_strobe_n_regrant;
  logic dly_start;
  logic grant_fire;
  logic tmr_run;

  // enable latch samples only at clock-high start; a valid
  // sample in the timeout cycle keeps the latch and grants again
  assign en_set = clk_high_start_in & gated_dma_request
                  & (~dma_enable_latch_q | timeout);

  assign ack_seen = grant_q & ~bus_select_ack_n_in;
  assign tmr_run  = grant_q & bus_select_ack_n_in;
  assign timeout  = tmr_run & (tmr_q == TMO_LAST);

  // act once on the falling edge of the strobe
  assign rearbitrate_strobe_n_evt     = ~rearbitrate_strobe_n & strobe_prev_q;
  assign rearbitrate_strobe_n_clear   = rearbitrate_strobe_n_evt & ~synced_dma_request;
  assign rearbitrate_strobe_n_regrant = rearbitrate_strobe_n_evt & synced_dma_request;

  assign dly_start  = en_set | rearbitrate_strobe_n_regrant;
  assign grant_fire = (dly_q == GNT_FIRE);

  // ==========================================================
  // next state
  // ==========================================================
  // a set in the same cycle as a clear wins
  assign dma_enable_latch_d =
    en_set ? 1'h1
    : (rearbitrate_strobe_n_clear | timeout) ? 1'h0
    : dma_enable_latch_q;

  assign dly_d = dly_start ? GNT_LOAD
               : (dly_q != GNT_IDLE) ? dly_q - GNT_FIRE
               : dly_q;

  assign grant_d = grant_fire ? 1'h1
                 : (ack_seen | timeout) ? 1'h0
                 : grant_q;

  assign bus_dis_d = grant_fire ? 1'h1
                   : (rearbitrate_strobe_n_clear | timeout) ? 1'h0
                   : bus_dis_q;

  // timer counts from the grant; acknowledge returns it to zero
  assign tmr_d = (tmr_run & ~timeout) ? tmr_q + TMO_STEP
               : TMO_ZERO;

  assign armed_d = ack_seen ? 1'h1
                 : rearbitrate_strobe_n_evt ? 1'h0
                 : armed_q;

  // ==========================================================
  // registers
  // ==========================================================
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      dma_enable_latch_q <= FLAG_RST;
      grant_q            <= FLAG_RST;
      bus_dis_q          <= FLAG_RST;
      armed_q            <= FLAG_RST;
      tmo_q              <= FLAG_RST;
      strobe_prev_q      <= STROBE_RST;
      dly_q              <= GNT_IDLE;
      tmr_q              <= TMO_ZERO;
    end else begin
      dma_enable_latch_q <= dma_enable_latch_d;
      grant_q            <= grant_d;
      bus_dis_q          <= bus_dis_d;
      armed_q            <= armed_d;
      tmo_q              <= timeout;
      strobe_prev_q      <= rearbitrate_strobe_n;
      dly_q              <= dly_d;
      tmr_q              <= tmr_d;
    end
  end

  // ==========================================================
  // outputs
  // ==========================================================
  assign bus_dma_grant_out_n_out = ~grant_q;
  assign bus_drivers_disable_out = bus_dis_q;
  // holds the processor clock stopped, so the cpu halts at
  // the end of its current bus cycle
  assign clk_restart_block_out = dma_enable_latch_q;
  assign ack_timeout_out       = tmo_q;

  // ==========================================================
  // checks
  // ==========================================================
  localparam int GNT_A = GNT_DLY_CYC;
  localparam int TMO_A = TMO_CYC;

  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!rst_b_in);

  property p_req_sync;
    !bus_dma_request_n_in ##1 !bus_dma_request_n_in
      |=> synced_dma_request;
  endproperty
  a_req_sync: assert property (p_req_sync)
    else $error("request not synchronised in two cycles");

  property p_gate;
    $rose(dma_enable_latch_q)
      |-> $past(cpu_bus_cycle_active_n_in)
          && $past(clk_high_start_in);
  endproperty
  a_gate: assert property (p_gate)
    else $error("enable set off clock-high or in bus cycle");

  property p_sample;
    clk_high_start_in && gated_dma_request |=> dma_enable_latch_q;
  endproperty
  a_sample: assert property (p_sample)
    else $error("valid gated request not latched");

  property p_grant_dly;
    $rose(dma_enable_latch_q)
      |-> !grant_q ##GNT_A grant_q;
  endproperty
  a_grant_dly: assert property (p_grant_dly)
    else $error("grant not asserted after enable delay");

  property p_disable;
    $rose(grant_q) |-> bus_drivers_disable_out
      && dma_enable_latch_q && tmr_q == TMO_ZERO;
  endproperty
  a_disable: assert property (p_disable)
    else $error("drivers not disabled with grant");

  property p_block;
    dma_enable_latch_q |-> clk_restart_block_out;
  endproperty
  a_block: assert property (p_block)
    else $error("clock restart not blocked during dma");

  property p_timeout;
    grant_q && tmr_q == TMO_LAST && bus_select_ack_n_in
      |=> !grant_q && ack_timeout_out && !bus_drivers_disable_out
          && (dma_enable_latch_q
              == $past(clk_high_start_in && gated_dma_request));
  endproperty
  a_timeout: assert property (p_timeout)
    else $error("no timeout withdrawal at the limit");

  property p_no_early_tmo;
    $rose(ack_timeout_out) |-> $past(tmr_q) == TMO_LAST;
  endproperty
  a_no_early_tmo: assert property (p_no_early_tmo)
    else $error("timeout before the full period");

  property p_ack;
    grant_q && !bus_select_ack_n_in
      |=> armed_q && !grant_q && tmr_q == TMO_ZERO;
  endproperty
  a_ack: assert property (p_ack)
    else $error("acknowledge did not arm restart");

  property p_strobe;
    $rose(rearbitrate_strobe_n_trig) |-> ##2 !rearbitrate_strobe_n;
  endproperty
  a_strobe: assert property (p_strobe)
    else $error("rearbitration strobe missing");

  property p_clear;
    rearbitrate_strobe_n_evt && !synced_dma_request && !en_set
      |=> !dma_enable_latch_q && !grant_q && !clk_restart_block_out;
  endproperty
  a_clear: assert property (p_clear)
    else $error("enable latch not cleared on idle rearbitration");

  property p_regrant;
    rearbitrate_strobe_n_evt && synced_dma_request
      |=> dma_enable_latch_q [*2] ##1 grant_q;
  endproperty
  a_regrant: assert property (p_regrant)
    else $error("pending request not regranted");

  property p_tmr_idle;
    !grant_q |=> tmr_q == TMO_ZERO;
  endproperty
  a_tmr_idle: assert property (p_tmr_idle)
    else $error("acknowledge timer ran without a grant");

  property p_block_hold;
    clk_restart_block_out && !rearbitrate_strobe_n_clear && !timeout
      |=> clk_restart_block_out;
  endproperty
  a_block_hold: assert property (p_block_hold)
    else $error("clock restart released during dma cycle");

  property p_grant_owner;
    grant_q |-> dma_enable_latch_q;
  endproperty
  a_grant_owner: assert property (p_grant_owner)
    else $error("grant present without enable latch");

  c_grant:   cover property ($rose(grant_q));
  c_ack:     cover property (ack_seen);
  c_timeout: cover property (timeout);
  c_clear:   cover property (rearbitrate_strobe_n_clear);
  c_regrant: cover property (rearbitrate_strobe_n_regrant);

endmodule : pdba_arbiter

`default_nettype wire

/* File: verif/pdba_periph.sv */
// peripheral dma controller model at the far side of the arbiter
// assumes one master on the grant chain; released bus lines pull high
`timescale 1ns/1ps
`default_nettype none

module pdba_periph (
  input  wire logic       sys_clk_in,
  input  wire logic       rst_b_in,
  input  wire logic       want_in,
  input  wire logic       no_ack_in,
  input  wire logic [3:0] ack_dly_in,
  input  wire logic       grant_n_in,
  output logic            request_n_out,
  output logic            select_ack_n_out,
  output logic            sync_n_out
);
  // ==========================================================
  // tenure sequencing
  // ==========================================================
  logic [1:0] phase_q;
  logic [3:0] cnt_q;
  logic       own;
  assign request_n_out    = ~want_in;
  assign own              = (phase_q == 2'h2);
  assign select_ack_n_out = ~own;
  assign sync_n_out       = ~own;
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      phase_q <= 2'h0;
      cnt_q   <= 4'h0;
    end else if (phase_q == 2'h0) begin
      // a requester blocks the grant and takes it
      if (want_in && !no_ack_in && !grant_n_in) begin
        phase_q <= 2'h1;
        cnt_q   <= ack_dly_in;
      end
    end else if (cnt_q != 4'h0) begin
      cnt_q <= cnt_q - 4'h1;
    end else begin
      // tenure kept to five cycles
      phase_q <= (phase_q == 2'h1) ? 2'h2 : 2'h0;
      cnt_q   <= 4'h4;
    end
  end
endmodule : pdba_periph
`default_nettype wire

/* File: verif/processor_dma_bus_arbiter_test.sv */
// self-checking bench for the dma bus arbiter
// assumes pdba_periph as the requesting peripheral
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, exp, got) begin \
  samples_checked++; \
  if ((got) !== (exp)) begin \
    n_mismatch++; \
    $display("unexpected %s expected %0h seen %0h", nm, exp, got); \
  end \
end

module processor_dma_bus_arbiter_test;
  import pdba_pkg::*;
  logic       clk, rst_b, start, cyc_n, want, no_ack;
  logic [3:0] ack_dly;
  logic [2:0] ph;
  logic       req_n, ack_n, sync_n, gnt_n, dis, blk, tmo;
  int         n_mismatch, samples_checked;

  // ==========================================================
  // clocks and instances
  // ==========================================================
  initial begin
    clk = 1'h0;
    forever #(CLK_PERIOD_NS / 2) clk = ~clk;
  end
  // clock-high start every seven board cycles
  always @(negedge clk) begin
    ph    <= (ph == 3'h6) ? 3'h0 : ph + 3'h1;
    start <= (ph == 3'h6);
  end
  pdba_arbiter dut_u (
    .sys_clk_in                (clk),
    .rst_b_in                  (rst_b),
    .clk_high_start_in         (start),
    .cpu_bus_cycle_active_n_in (cyc_n),
    .bus_dma_request_n_in      (req_n),
    .bus_select_ack_n_in       (ack_n),
    .bus_sync_n_in             (sync_n),
    .bus_dma_grant_out_n_out   (gnt_n),
    .bus_drivers_disable_out   (dis),
    .clk_restart_block_out     (blk),
    .ack_timeout_out           (tmo)
  );
  pdba_periph periph_u (
    .sys_clk_in       (clk),
    .rst_b_in         (rst_b),
    .want_in          (want),
    .no_ack_in        (no_ack),
    .ack_dly_in       (ack_dly),
    .grant_n_in       (gnt_n),
    .request_n_out    (req_n),
    .select_ack_n_out (ack_n),
    .sync_n_out       (sync_n)
  );

  // ==========================================================
  // shared tasks
  // ==========================================================
  task automatic test_done;
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : test_done
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask : tick
  // sel 0 waits on the halt flag, sel 1 on the acknowledge
  task automatic wait_for(input bit sel, input logic v);
    int i;
    for (i = 0; i < 60 && (sel ? ack_n : blk) !== v; i++) tick(1);
    `CHK("wait", v, sel ? ack_n : blk)
  endtask : wait_for
  task automatic start_grant;
    want = 1'h1;
    wait_for(1'b0, 1'h1);
    `CHK("grant", 1'h1, gnt_n)
    tick(1);
    `CHK("grant", 1'h1, gnt_n)
    tick(1);
    `CHK("grant", 1'h0, gnt_n)
    `CHK("disable", 1'h1, dis)
  endtask : start_grant
  task automatic finish(input bit keep);
    wait_for(1'b1, 1'h0);
    tick(1);
    `CHK("grant", 1'h1, gnt_n)
    `CHK("halt", 1'h1, blk)
    want = keep;
    wait_for(1'b1, 1'h1);
    tick(2);
    `CHK("halt", 1'h1, blk)
    tick(1);
    `CHK("halt", keep, blk)
    if (keep) begin
      tick(2);
      `CHK("regrant", 1'h0, gnt_n)
    end else begin
      `CHK("disable", 1'h0, dis)
    end
  endtask : finish

  // ==========================================================
  // scenarios
  // ==========================================================
  task automatic t_reset;
    `CHK("grant", 1'h1, gnt_n)
    `CHK("disable", 1'h0, dis)
    `CHK("halt", 1'h0, blk)
    `CHK("timeout", 1'h0, tmo)
    $display("test reset done");
  endtask : t_reset
  task automatic t_cpu_cycle;
    cyc_n = 1'h0;
    want  = 1'h1;
    tick(30);
    `CHK("halt", 1'h0, blk)
    cyc_n = 1'h1;
    start_grant();
    finish(1'b0);
    $display("test cpu cycle done");
  endtask : t_cpu_cycle
  task automatic t_rearbitrate_strobe_n;
    ack_dly = 4'h6;
    start_grant();
    finish(1'b1);
    finish(1'b0);
    $display("test rearbitration done");
  endtask : t_rearbitrate_strobe_n
  task automatic t_timeout;
    no_ack = 1'h1;
    start_grant();
    want = 1'h0;
    tick(TMO_CYC - 1);
    `CHK("grant", 1'h0, gnt_n)
    tick(1);
    `CHK("grant", 1'h1, gnt_n)
    `CHK("halt", 1'h0, blk)
    `CHK("timeout", 1'h1, tmo)
    tick(1);
    `CHK("timeout", 1'h0, tmo)
    no_ack = 1'h0;
    $display("test timeout done");
  endtask : t_timeout

  // ==========================================================
  // main sequence and watchdog
  // ==========================================================
  initial begin
    rst_b           = 1'h0;
    cyc_n           = 1'h1;
    want            = 1'h0;
    no_ack          = 1'h0;
    ack_dly         = 4'h0;
    ph              = 3'h0;
    start           = 1'h0;
    n_mismatch      = 0;
    samples_checked = 0;
    tick(2);
    rst_b = 1'h1;
    tick(1);
    t_reset();
    t_cpu_cycle();
    t_rearbitrate_strobe_n();
    t_timeout();
    test_done();
  end
  initial begin
    #(CLK_PERIOD_NS * 5000);
    n_mismatch++;
    test_done();
  end
endmodule : processor_dma_bus_arbiter_test
`default_nettype wire
